// ==== toc_timer.sv ====
// Counter core, APB register file and pin logic of the timer output compare block.
`timescale 1ns/10ps
`default_nettype none
module toc_timer
  import toc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_tick,
  input wire logic [15:0] capture_value,
  input wire logic overflow_irq_ack,
  input wire logic [1:0] compare_irq_ack,
  output logic overflow_irq,
  output logic [1:0] compare_irq,
  input wire logic [1:0] port_out_val,
  input wire logic [1:0] output_pin_direction,
  output logic [1:0] waveform_output,
  output logic [1:0] waveform_oe_n
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] temp;
    logic block;
    logic [2:0] flags;
    logic [3:0] wgm;
    logic [2:0] cs;
    logic [1:0] com_b;
    logic [1:0] com_a;
    logic [2:0] ie;
    logic [31:0] rdata;
  } toc_top_state_t;

  toc_top_state_t st_r;
  toc_top_state_t st_nxt;

  toc_chan_if ch_if [NUM_CH] ();

  logic setup_ph;
  logic acc_ph;
  logic wr_acc;
  logic mapped;
  logic run;
  logic pwm;
  logic [15:0] top;
  logic at_top;
  logic cnt_wr;
  logic [1:0] cmp_wr;
  logic [1:0] fire;
  logic [1:0] flag_hit;
  logic [1:0] wave;
  logic [3:0] com_all;

  assign setup_ph = psel && !penable;
  assign acc_ph = psel && penable;
  assign wr_acc = acc_ph && pwrite;
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_FORCE) || (paddr == ADDR_FLAGS) ||
                  (paddr == ADDR_CNT_LO) || (paddr == ADDR_CNT_HI) ||
                  (paddr == ADDR_CMPA_LO) || (paddr == ADDR_CMPA_HI) ||
                  (paddr == ADDR_CMPB_LO) || (paddr == ADDR_CMPB_HI) ||
                  (paddr == ADDR_STATUS);
  assign pready = acc_ph;
  assign pslverr = acc_ph && !mapped;
  assign prdata = st_r.rdata;

  assign run = timer_tick && (st_r.cs != CS_STOP);
  assign pwm = toc_is_pwm(st_r.wgm);
  assign top = toc_top(st_r.wgm, ch_if[0].cmp_act, capture_value);
  assign at_top = (st_r.cnt == top) && !st_r.block;
  assign cnt_wr = wr_acc && (paddr == ADDR_CNT_LO);
  assign cmp_wr[0] = wr_acc && (paddr == ADDR_CMPA_LO);
  assign cmp_wr[1] = wr_acc && (paddr == ADDR_CMPB_LO);
  assign fire = (wr_acc && (paddr == ADDR_FORCE) && !pwm) ? pwdata[1:0] : 2'b00;
  assign com_all = {st_r.com_b, st_r.com_a};

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      assign ch_if[i].tick = run;
      assign ch_if[i].cnt = st_r.cnt;
      assign ch_if[i].blocked = st_r.block;
      assign ch_if[i].wrap = run && at_top && !cnt_wr;
      assign ch_if[i].pwm = pwm;
      assign ch_if[i].act_sel = com_all[2*i +: 2];
      assign ch_if[i].wr_en = cmp_wr[i];
      assign ch_if[i].wr_data = {st_r.temp, pwdata[7:0]};
      assign ch_if[i].force_hit = fire[i];
      assign flag_hit[i] = ch_if[i].flag_set;
      assign wave[i] = ch_if[i].wave;
      toc_chan u_chan (
        .sys_clk(sys_clk),
        .reset(reset),
        .bus(ch_if[i])
      );
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      waveform_output[i] = (com_all[2*i +: 2] != COM_OFF) ? wave[i] : port_out_val[i];
      waveform_oe_n[i] = !output_pin_direction[i];
    end
  end

  assign overflow_irq = st_r.flags[FLAG_OVF] && st_r.ie[FLAG_OVF];
  assign compare_irq[0] = st_r.flags[FLAG_A] && st_r.ie[FLAG_A];
  assign compare_irq[1] = st_r.flags[FLAG_B] && st_r.ie[FLAG_B];

  always_comb begin
    logic [2:0] set_v;
    logic [2:0] clr_v;
    logic [31:0] rd;
    logic [15:0] cmp_sel;
    set_v = 3'h0;
    clr_v = 3'h0;
    rd = 32'h0000_0000;
    cmp_sel = 16'h0000;
    st_nxt = st_r;

    if (cnt_wr) begin
      st_nxt.cnt = {st_r.temp, pwdata[7:0]};
      st_nxt.block = 1'b1;
    end else if (run) begin
      st_nxt.cnt = at_top ? CNT_RST : st_r.cnt + 16'h0001;
      st_nxt.block = 1'b0;
    end

    if (run && !cnt_wr) begin
      if (pwm) begin
        set_v[FLAG_OVF] = at_top;
      end else begin
        set_v[FLAG_OVF] = (st_r.cnt == CNT_MAX);
      end
    end
    set_v[FLAG_A] = flag_hit[0];
    set_v[FLAG_B] = flag_hit[1];

    if (wr_acc && (paddr == ADDR_FLAGS)) begin
      clr_v = pwdata[2:0];
    end
    clr_v[FLAG_OVF] = clr_v[FLAG_OVF] || overflow_irq_ack;
    clr_v[FLAG_A] = clr_v[FLAG_A] || compare_irq_ack[0];
    clr_v[FLAG_B] = clr_v[FLAG_B] || compare_irq_ack[1];
    st_nxt.flags = (st_r.flags & ~clr_v) | set_v;

    // High byte writes load the latch.
    if (wr_acc) begin
      if (paddr == ADDR_CNT_HI || paddr == ADDR_CMPA_HI || paddr == ADDR_CMPB_HI) begin
        st_nxt.temp = pwdata[7:0];
      end else if (paddr == ADDR_CTRL) begin
        st_nxt.wgm = pwdata[CTRL_WGM_LSB +: 4];
        st_nxt.cs = pwdata[CTRL_CS_LSB +: 3];
        st_nxt.com_a = pwdata[CTRL_COMA_LSB +: 2];
        st_nxt.com_b = pwdata[CTRL_COMB_LSB +: 2];
        st_nxt.ie = pwdata[CTRL_IE_LSB +: 3];
      end
    end

    // Read data is captured in the setup phase.
    if (setup_ph && !pwrite) begin
      if (paddr == ADDR_CTRL) begin
        rd[CTRL_WGM_LSB +: 4] = st_r.wgm;
        rd[CTRL_CS_LSB +: 3] = st_r.cs;
        rd[CTRL_COMA_LSB +: 2] = st_r.com_a;
        rd[CTRL_COMB_LSB +: 2] = st_r.com_b;
        rd[CTRL_IE_LSB +: 3] = st_r.ie;
      end else if (paddr == ADDR_FLAGS) begin
        rd[2:0] = st_r.flags;
      end else if (paddr == ADDR_CNT_LO) begin
        rd[7:0] = st_r.cnt[7:0];
        st_nxt.temp = st_r.cnt[15:8];
      end else if (paddr == ADDR_CNT_HI) begin
        rd[7:0] = st_r.temp;
      end else if (paddr == ADDR_CMPA_LO || paddr == ADDR_CMPA_HI) begin
        cmp_sel = pwm ? ch_if[0].cmp_buf : ch_if[0].cmp_act;
        rd[7:0] = (paddr == ADDR_CMPA_LO) ? cmp_sel[7:0] : cmp_sel[15:8];
      end else if (paddr == ADDR_CMPB_LO || paddr == ADDR_CMPB_HI) begin
        cmp_sel = pwm ? ch_if[1].cmp_buf : ch_if[1].cmp_act;
        rd[7:0] = (paddr == ADDR_CMPB_LO) ? cmp_sel[7:0] : cmp_sel[15:8];
      end else if (paddr == ADDR_STATUS) begin
        rd[STAT_WAVE_LSB +: 2] = wave;
        rd[STAT_PIN_LSB +: 2] = waveform_output;
      end
      st_nxt.rdata = rd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '{cnt: CNT_RST, temp: 8'h00, block: 1'b0, flags: 3'h0, wgm: WGM_RST,
                cs: CS_RST, com_b: COM_RST, com_a: COM_RST, ie: IE_RST, rdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : toc_timer
`default_nettype wire

// ==== toc_pkg.sv ====
// Constants, register map and shared helpers for the timer output compare block.
// Functional notes
// - Each channel compares the 16-bit counter with its compare value continuously.
// - A match sets the channel flag at the next timer clock, not at once.
// - An enabled set flag requests an interrupt; executing it clears the flag.
// - Writing one to a flag bit clears it; writing zero leaves it.
// - Channel A can set the counter TOP and so the waveform period.
// - Compare values are double buffered in PWM modes, not in Normal or clear-on-match.
// - Buffered compare values load into the active register only at TOP.
// - Writes go to the buffer when buffered, else straight to the active register.
// - Compare values change only by writes; high byte reads return the register itself.
// - The low byte write copies the latched high byte in the same cycle.
// - A force strobe in non-PWM modes applies the output action without flag or reload.
// - A counter write blocks all compare matches in the next timer clock.
// - Writing the counter equal to a variable TOP misses TOP; counting runs to 0xFFFF.
// - The waveform output register keeps its value across waveform mode changes.
// - Output action bits are unbuffered and govern the first match after the write.
// - Reset clears each waveform output register to zero.
// - A nonzero output action overrides the port value; the direction bit enables the pin.
// - Output action zero leaves the waveform output unchanged at matches in every mode.
// - Output action bits have no effect on input capture.
// - Normal mode counts up without clearing and wraps from 0xFFFF to 0x0000.
// - In Normal mode overflow sets as the counter becomes zero; counting never clears it.
// - A counter write takes priority over clear or count in the same cycle.
// - Clock source zero stops the counter, which stays accessible to software.
package toc_pkg;
  localparam int NUM_CH = 2;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FORCE = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_CNT_LO = 8'h0C;
  localparam logic [7:0] ADDR_CNT_HI = 8'h10;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h14;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h18;
  localparam logic [7:0] ADDR_CMPB_LO = 8'h1C;
  localparam logic [7:0] ADDR_CMPB_HI = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_CS_LSB = 4;
  localparam int CTRL_COMA_LSB = 8;
  localparam int CTRL_COMB_LSB = 10;
  localparam int CTRL_IE_LSB = 16;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_A = 1;
  localparam int FLAG_B = 2;
  localparam int STAT_WAVE_LSB = 0;
  localparam int STAT_PIN_LSB = 4;
  localparam logic [3:0] WGM_RST = 4'h0;
  localparam logic [2:0] CS_RST = 3'h0;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [1:0] COM_RST = 2'h0;
  localparam logic [2:0] IE_RST = 3'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_CTC_CAP = 4'hC;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // True in every mode that buffers the compare value.
  function automatic logic toc_is_pwm(input logic [3:0] wgm);
    toc_is_pwm = !(wgm == WGM_NORMAL || wgm == WGM_CTC_A || wgm == WGM_CTC_CAP);
  endfunction : toc_is_pwm

  // TOP value selected by the waveform mode.
  function automatic logic [15:0] toc_top(input logic [3:0] wgm, input logic [15:0] cmp_a,
                                          input logic [15:0] cap);
    case (wgm)
      4'h1, 4'h5: toc_top = TOP_8BIT;
      4'h2, 4'h6: toc_top = TOP_9BIT;
      4'h3, 4'h7: toc_top = TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: toc_top = cmp_a;
      4'h8, 4'hA, 4'hC, 4'hE: toc_top = cap;
      default: toc_top = CNT_MAX;
    endcase
  endfunction : toc_top

  // Next waveform level for a match or force (bottom low) or a PWM bottom (bottom high).
  function automatic logic toc_next_wave(input logic [1:0] com, input logic pwm,
                                         input logic bottom, input logic wave);
    toc_next_wave = wave;
    if (!pwm) begin
      if (!bottom) begin
        case (com)
          COM_TOGGLE: toc_next_wave = ~wave;
          COM_CLEAR: toc_next_wave = 1'b0;
          COM_SET: toc_next_wave = 1'b1;
          default: toc_next_wave = wave;
        endcase
      end
    end else if (com == COM_CLEAR) begin
      toc_next_wave = bottom;
    end else if (com == COM_SET) begin
      toc_next_wave = ~bottom;
    end
  endfunction : toc_next_wave
endpackage : toc_pkg

// ==== toc_chan_if.sv ====
// Interface between the counter core and one compare channel.
`timescale 1ns/10ps
`default_nettype none
interface toc_chan_if;
  logic tick;
  logic [15:0] cnt;
  logic blocked;
  logic wrap;
  logic pwm;
  logic [1:0] act_sel;
  logic wr_en;
  logic [15:0] wr_data;
  logic force_hit;
  logic match;
  logic flag_set;
  logic [15:0] cmp_act;
  logic [15:0] cmp_buf;
  logic wave;
  modport chan (
    input tick, cnt, blocked, wrap, pwm, act_sel, wr_en, wr_data, force_hit,
    output match, flag_set, cmp_act, cmp_buf, wave
  );
  modport ctl (
    output tick, cnt, blocked, wrap, pwm, act_sel, wr_en, wr_data, force_hit,
    input match, flag_set, cmp_act, cmp_buf, wave
  );
endinterface : toc_chan_if
`default_nettype wire

// ==== toc_chan.sv ====
// One output compare channel: buffered compare value, comparator and waveform register.
`timescale 1ns/10ps
`default_nettype none
module toc_chan
  import toc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  toc_chan_if.chan bus
);
  typedef struct packed {
    logic [15:0] buffer;
    logic [15:0] active;
    logic hit;
    logic wave;
  } toc_chan_state_t;

  toc_chan_state_t st_r;
  toc_chan_state_t st_nxt;

  assign bus.match = (bus.cnt == st_r.active) && !bus.blocked;
  // Flag set one timer clock later.
  assign bus.flag_set = bus.tick && st_r.hit;
  assign bus.cmp_act = st_r.active;
  assign bus.cmp_buf = st_r.buffer;
  assign bus.wave = st_r.wave;

  always_comb begin
    st_nxt = st_r;
    if (bus.tick) begin
      st_nxt.hit = bus.match;
    end
    if (bus.wr_en) begin
      st_nxt.buffer = bus.wr_data;
      if (!bus.pwm) begin
        st_nxt.active = bus.wr_data;
      end
    end else if (bus.pwm && bus.wrap) begin
      st_nxt.active = st_r.buffer;
    end
    if (bus.tick && bus.match) begin
      st_nxt.wave = toc_next_wave(bus.act_sel, bus.pwm, 1'b0, st_r.wave);
    end else if (bus.pwm && bus.wrap) begin
      st_nxt.wave = toc_next_wave(bus.act_sel, bus.pwm, 1'b1, st_r.wave);
    end else if (bus.force_hit) begin
      st_nxt.wave = toc_next_wave(bus.act_sel, 1'b0, 1'b0, st_r.wave);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '{buffer: CMP_RST, active: CMP_RST, hit: 1'b0, wave: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : toc_chan
`default_nettype wire

// ==== toc_timer_chk.sv ====
// Port-level assertions for the timer output compare block.
`timescale 1ns/10ps
`default_nettype none
module toc_timer_chk
  import toc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic timer_tick,
  input wire logic overflow_irq,
  input wire logic [1:0] compare_irq,
  input wire logic [1:0] compare_irq_ack,
  input wire logic [1:0] port_out_val,
  input wire logic [1:0] output_pin_direction,
  input wire logic [1:0] waveform_output,
  input wire logic [1:0] waveform_oe_n
);
  logic [31:0] ctl_r;
  logic [2:0] ie;
  logic [3:0] wgm;
  logic [1:0] com_a;
  logic wr, frc, fwr, pwm, run;
  assign wr = psel & penable & pwrite;
  assign frc = wr && paddr == ADDR_FORCE && pwdata[0];
  assign fwr = wr && paddr == ADDR_FLAGS;
  assign ie = ctl_r[CTRL_IE_LSB +: 3];
  assign wgm = ctl_r[CTRL_WGM_LSB +: 4];
  assign com_a = ctl_r[CTRL_COMA_LSB +: 2];
  assign pwm = !(wgm == WGM_NORMAL || wgm == WGM_CTC_A || wgm == WGM_CTC_CAP);
  assign run = ctl_r[CTRL_CS_LSB +: 3] != CS_STOP;
  // Shadow copy of the control register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl_r <= 32'h0000_0000;
    end else if (wr && paddr == ADDR_CTRL) begin
      ctl_r <= pwdata;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  pin_enable_a: assert property (
    waveform_oe_n == ~output_pin_direction) else $error("pin enable wrong");
  port_pass_a: assert property (
    com_a == COM_OFF |-> waveform_output[0] == port_out_val[0]) else $error("port not passed");
  irq_gate_a: assert property (
    compare_irq[0] |-> ie[1]) else $error("irq without enable");
  ack_clear_a: assert property (
    compare_irq_ack[0] && !timer_tick |=> !compare_irq[0]) else $error("ack kept flag");
  one_clear_a: assert property (
    fwr && pwdata[FLAG_A] && !timer_tick |=> !compare_irq[0]) else $error("one kept flag");
  zero_keep_a: assert property (
    fwr && !pwdata[FLAG_A] && compare_irq[0] && !compare_irq_ack[0] |=> compare_irq[0])
    else $error("zero cleared flag");
  tick_only_a: assert property (
    $rose(compare_irq[1]) && $past(ie[2]) |-> $past(timer_tick)) else $error("flag off tick");
  stop_hold_a: assert property (
    $rose(overflow_irq) && $past(ie[0]) |-> $past(run) && $past(timer_tick))
    else $error("overflow while stopped");
  force_wave_a: assert property (
    frc && !pwm && com_a == COM_SET |=> waveform_output[0]) else $error("force not applied");
  force_flag_a: assert property (
    frc && !timer_tick && !compare_irq_ack[0] |=> $stable(compare_irq[0]))
    else $error("force touched flag");
  cover property (frc && !pwm);
  cover property ($rose(overflow_irq));
  cover property ($rose(compare_irq[1]));
endmodule : toc_timer_chk
bind toc_timer toc_timer_chk toc_timer_chk_inst (
  .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .timer_tick, .overflow_irq,
  .compare_irq, .compare_irq_ack, .port_out_val, .output_pin_direction, .waveform_output,
  .waveform_oe_n
);
`default_nettype wire

// ==== toc_host_model.sv ====
// Prescaler tick and interrupt acknowledge model facing the timer.
`timescale 1ns/10ps
`default_nettype none
module toc_host_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ack_en,
  input wire logic overflow_irq,
  input wire logic [1:0] compare_irq,
  output logic timer_tick,
  output logic overflow_irq_ack,
  output logic [1:0] compare_irq_ack
);
  logic [1:0] div_r;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_r <= 2'h0;
      timer_tick <= 1'b0;
      overflow_irq_ack <= 1'b0;
      compare_irq_ack <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
      timer_tick <= (div_r == 2'h3);
      overflow_irq_ack <= ack_en & overflow_irq & ~overflow_irq_ack;
      compare_irq_ack <= {2{ack_en}} & compare_irq & ~compare_irq_ack;
    end
  end
endmodule : toc_host_model
`default_nettype wire

// ==== toc_timer_bench.sv ====
// Self-checking testbench for the timer output compare block.
`timescale 1ns/10ps
`default_nettype none
module toc_timer_bench
  import toc_pkg::*;
;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, rerr, ack_en;
  logic timer_tick, overflow_irq, overflow_irq_ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] compare_irq, compare_irq_ack, port_out_val, output_pin_direction;
  logic [1:0] waveform_output, waveform_oe_n;
  logic [2:0] irqv;
  logic [1:0] coms [4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_OFF};
  logic [3:0] wv = 4'b1101;
  int miscompares, check_count, i;
  assign irqv = {compare_irq, overflow_irq};
  toc_timer toc_timer_inst (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timer_tick, .capture_value(16'h0000), .overflow_irq_ack,
    .compare_irq_ack, .overflow_irq, .compare_irq, .port_out_val, .output_pin_direction,
    .waveform_output, .waveform_oe_n);
  toc_host_model toc_host_model_inst (.sys_clk, .reset, .ack_en, .overflow_irq,
    .compare_irq, .timer_tick, .overflow_irq_ack, .compare_irq_ack);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    apb(1'b1, a, {24'h0, v[15:8]});
    apb(1'b1, a - 8'h04, {24'h0, v[7:0]});
  endtask : wr16
  task automatic hit(input int b, input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (irqv[b] !== 1'b1 && n < 4000);
    if (irqv[b] !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rd(ADDR_CNT_LO, {24'h0, e});
  endtask : hit
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic [2:0] c,
                                      input logic [1:0] a, input logic [2:0] ie);
    ctl = {13'h0, ie, 4'h0, 2'h0, a, 1'b0, c, m};
  endfunction : ctl
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset = 1'b1;
    ack_en = 1'b0;
    port_out_val = 2'b10;
    output_pin_direction = 2'b01;
    miscompares = 0;
    check_count = 0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_STATUS, 32'h20); // Waves start low.
    chk({28'h0, waveform_oe_n, waveform_output}, 32'h0000_000A); // Pins follow port.
    apb(1'b0, 8'h28, 32'h0);
    chk({rdat[31:1], rerr}, 32'h1);
    wr16(ADDR_CMPA_HI, 16'h1234);
    rd(ADDR_CMPA_HI, 32'h12); // High byte direct.
    rd(ADDR_CMPA_LO, 32'h34); // Low byte direct.
    for (i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CTRL, ctl(WGM_NORMAL, CS_STOP, coms[i], 3'h0));
      apb(1'b1, ADDR_FORCE, 32'h1);
      rd(ADDR_STATUS, {26'h0, 1'b1, (coms[i] != COM_OFF) & wv[i], 3'h0, wv[i]});
      chk({30'h0, waveform_output}, {30'h0, 1'b1, (coms[i] != COM_OFF) & wv[i]});
    end
    rd(ADDR_FLAGS, 32'h0); // Force sets no flag.
    apb(1'b1, ADDR_CTRL, ctl(4'h5, CS_STOP, COM_CLEAR, 3'h0));
    apb(1'b1, ADDR_FORCE, 32'h1);
    rd(ADDR_STATUS, 32'h31); // Wave kept.
    apb(1'b1, ADDR_CTRL, ctl(WGM_NORMAL, CS_STOP, COM_TOGGLE, 3'h0));
    wr16(ADDR_CMPA_HI, 16'h0005);
    wr16(ADDR_CMPB_HI, 16'h0020);
    wr16(ADDR_CNT_HI, 16'h0002);
    apb(1'b1, ADDR_CTRL, ctl(WGM_NORMAL, 3'h1, COM_TOGGLE, 3'h2));
    hit(1, 8'h07); // Flag one tick late.
    rd(ADDR_STATUS, 32'h20); // Toggled on match.
    apb(1'b1, ADDR_FLAGS, 32'h0);
    rd(ADDR_FLAGS, 32'h2); // Zero keeps flag.
    apb(1'b1, ADDR_FLAGS, 32'h2);
    rd(ADDR_FLAGS, 32'h0); // One clears flag.
    wr16(ADDR_CNT_HI, 16'h0005);
    repeat (40) @(posedge sys_clk);
    rd(ADDR_FLAGS, 32'h0); // Match blocked.
    ack_en <= 1'b1;
    apb(1'b1, ADDR_CTRL, ctl(WGM_NORMAL, 3'h1, COM_OFF, 3'h1));
    wr16(ADDR_CNT_HI, 16'hFFFD);
    hit(0, 8'h00); // Overflow at wrap.
    rd(ADDR_FLAGS, 32'h0); // Cleared by ack.
    apb(1'b1, ADDR_CTRL, ctl(WGM_CTC_A, CS_STOP, COM_OFF, 3'h2));
    wr16(ADDR_CNT_HI, 16'h0000);
    apb(1'b1, ADDR_CTRL, ctl(WGM_CTC_A, 3'h1, COM_OFF, 3'h2));
    hit(1, 8'h01); // Channel A is top.
    hit(1, 8'h01); // Period repeats.
    apb(1'b1, ADDR_CTRL, ctl(4'h5, CS_STOP, COM_OFF, 3'h0));
    wr16(ADDR_CMPB_HI, 16'h0042);
    rd(ADDR_CMPB_LO, 32'h42); // Buffer read back.
    wr16(ADDR_CNT_HI, 16'h001E);
    apb(1'b1, ADDR_FLAGS, 32'h7);
    apb(1'b1, ADDR_CTRL, ctl(4'h5, 3'h1, COM_OFF, 3'h4));
    hit(2, 8'h22); // Active value kept.
    hit(2, 8'h44); // Loaded at top.
    finish_test();
  end
endmodule : toc_timer_bench
`default_nettype wire
